// >>> rtl/uirq_top.v
// APB-facing OUT endpoint and bus event interrupt flag block
`timescale 1ns/1ps
`include "uirq_defines.vh"
module uirq_top (
	// Clock and reset
	input wire clock_i,
	input wire arst_n_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output reg [31:0] prdata_o,
	output wire pslverr_o,
	// Endpoint and bus events, one-cycle pulses; suspend_mode_i is a level
	input wire out_ep1_evt_i,
	input wire out_ep2_evt_i,
	input wire out_ep3_evt_i,
	input wire sof_token_i,
	input wire bus_reset_evt_i,
	input wire resume_evt_i,
	input wire suspend_evt_i,
	input wire suspend_mode_i,
	// Interrupt
	output wire irq_o
);
	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	reg [7:0] out_mask_r;
	reg [7:0] bus_mask_r;
	reg [7:0] ctrl_r;
	wire [7:0] out_flags;
	wire [7:0] bus_flags;
	wire [7:0] out_set;
	wire [7:0] bus_set;
	wire [7:0] out_keep;
	wire [7:0] bus_keep;
	wire access;
	wire wr;
	wire rd;
	wire sof_evt;
	wire suspend_detect_enable;
	wire hit_out;
	wire hit_bus;
	wire hit_omask;
	wire hit_bmask;
	wire hit_ctrl;
	wire mapped;

	function is_reg;
		input [7:0] addr;
		input [5:0] idx;
		begin
			is_reg = (addr == {idx, 2'b00});
		end
	endfunction

	assign access = psel_i & penable_i;
	assign wr = access & pwrite_i;
	assign rd = access & ~pwrite_i;
	assign hit_out = is_reg(paddr_i, `UIRQ_IDX_OUT_FLAGS);
	assign hit_bus = is_reg(paddr_i, `UIRQ_IDX_BUS_FLAGS);
	assign hit_omask = is_reg(paddr_i, `UIRQ_IDX_OUT_MASK);
	assign hit_bmask = is_reg(paddr_i, `UIRQ_IDX_BUS_MASK);
	assign hit_ctrl = is_reg(paddr_i, `UIRQ_IDX_CTRL);
	assign mapped = hit_out | hit_bus | hit_omask | hit_bmask | hit_ctrl;
	// Zero wait states
	assign pready_o = 1'b1;
	// Writes to read-only flag registers are ignored, not errors
	assign pslverr_o = access & ~mapped;
	assign suspend_detect_enable = ctrl_r[`UIRQ_BIT_SUSPEND_DETECT_ENABLE];

	// ----------------------------------------
	// Event mapping
	// ----------------------------------------
	assign out_set = {4'h0, out_ep3_evt_i, out_ep2_evt_i, out_ep1_evt_i, 1'b0}; // see [RULE_01]
	assign bus_set = {4'h0,
		sof_evt, // see [RULE_04]
		bus_reset_evt_i, // see [RULE_06]
		resume_evt_i & suspend_mode_i, // see [RULE_07]
		suspend_evt_i & suspend_detect_enable}; // see [RULE_09]

	// Flags raised after the setup capture were not returned, so the clear must spare them
	assign out_keep = out_flags & ~prdata_o[7:0];
	assign bus_keep = bus_flags & ~prdata_o[7:0];

	uirq_sof_synth u_sof (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.sof_token_i(sof_token_i),
		.enable_i(~suspend_mode_i),
		.sof_evt_o(sof_evt)
	);

	// Read clears only the register addressed
	uirq_flag_reg u_out_flags (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.set_i(out_set | out_keep),
		.valid_i(`UIRQ_OUT_VALID),
		.rd_clr_i(rd & hit_out), // see [RULE_03]
		.flags_o(out_flags)
	);

	uirq_flag_reg u_bus_flags (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.set_i(bus_set | bus_keep),
		.valid_i(`UIRQ_BUS_VALID),
		.rd_clr_i(rd & hit_bus), // see [RULE_08]
		.flags_o(bus_flags)
	);

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_mask_r <= `UIRQ_RST_OUT_MASK;
			bus_mask_r <= `UIRQ_RST_BUS_MASK;
			ctrl_r <= `UIRQ_RST_CTRL;
		end else if (wr) begin
			if (hit_omask) begin
				out_mask_r <= pwdata_i[7:0] & `UIRQ_OUT_VALID;
			end else if (hit_bmask) begin
				bus_mask_r <= pwdata_i[7:0] & `UIRQ_BUS_VALID;
			end else if (hit_ctrl) begin
				ctrl_r <= pwdata_i[7:0] & 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Read data, registered at the setup edge
	// ----------------------------------------
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o <= 32'h00000000;
		end else if (psel_i & ~penable_i & ~pwrite_i) begin
			// Captured in setup so the access phase returns the pre-clear value
			if (hit_out) begin
				prdata_o <= {24'h000000, out_flags}; // see [RULE_02]
			end else if (hit_bus) begin
				prdata_o <= {24'h000000, bus_flags};
			end else if (hit_omask) begin
				prdata_o <= {24'h000000, out_mask_r};
			end else if (hit_bmask) begin
				prdata_o <= {24'h000000, bus_mask_r};
			end else if (hit_ctrl) begin
				prdata_o <= {24'h000000, ctrl_r};
			end else begin
				prdata_o <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	assign irq_o = |((out_flags & out_mask_r) | (bus_flags & bus_mask_r)); // see [RULE_11]
endmodule

// >>> shared/uirq_defines.vh
// Constants for the USB OUT endpoint and bus event interrupt flag block
// Functional notes
// [RULE_01] OUT flag register holds endpoint 3,2,1 pending flags at bits 3,2,1.
// [RULE_02] OUT flags read 1 when active, 0 when inactive; register read-only.
// [RULE_03] Reading the OUT flag register returns flags then clears them all.
// [RULE_04] Bus event register sets start-of-frame flag at bit 3 on frame token.
// [RULE_05] Start-of-frame flag also set when frame expected, token lost or corrupt.
// [RULE_06] Bus reset flag at bit 2 set when reset signaling detected.
// [RULE_07] Resume flag at bit 1 set only on resume while suspended.
// [RULE_08] Reading bus event register clears its four flags after returning them.
// [RULE_09] Suspend flag at bit 0 set on suspend only while detection enabled.
// [RULE_10] Unused bits read zero; writes have no effect.
// [RULE_11] Single interrupt request asserted while any pending flag is one. Code ORs only flags enabled in the mask registers.
// [RULE_12] Reading one flag register clears only that register's flags.
`ifndef UIRQ_DEFINES_VH
`define UIRQ_DEFINES_VH

// ----------------------------------------
// Register indices; byte address is the index times four
// ----------------------------------------
`define UIRQ_IDX_OUT_FLAGS 6'h04
`define UIRQ_IDX_BUS_FLAGS 6'h06
`define UIRQ_IDX_OUT_MASK 6'h09
`define UIRQ_IDX_BUS_MASK 6'h0B
`define UIRQ_IDX_CTRL 6'h10
`define UIRQ_IDX_FRAME_TIMER 6'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UIRQ_BIT_OUT_EP1_PENDING 1
`define UIRQ_BIT_OUT_EP2_PENDING 2
`define UIRQ_BIT_OUT_EP3_PENDING 3
`define UIRQ_BIT_SOF 3
`define UIRQ_BIT_RST 2
`define UIRQ_BIT_RSU 1
`define UIRQ_BIT_SUS 0
`define UIRQ_BIT_SUSPEND_DETECT_ENABLE 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UIRQ_RST_FLAGS 8'h00
`define UIRQ_RST_OUT_MASK 8'h0E
`define UIRQ_RST_BUS_MASK 8'h06
`define UIRQ_RST_CTRL 8'h01
`define UIRQ_OUT_VALID 8'h0E
`define UIRQ_BUS_VALID 8'h0F

// ----------------------------------------
// Frame timing: 1 ms frame, 125 MHz clock, 8 ns period
// ----------------------------------------
`define UIRQ_FRAME_NS 1000000
`define UIRQ_CLK_NS 8
`define UIRQ_FRAME_CYC (`UIRQ_FRAME_NS / `UIRQ_CLK_NS)
`define UIRQ_SOF_SLACK_CYC 16'h0040

`endif

// >>> rtl/uirq_sof_synth.v
// Start-of-frame synthesizer: fires on a token or when one is overdue
`timescale 1ns/1ps
`include "uirq_defines.vh"
module uirq_sof_synth #(
	parameter FRAME_CYC = `UIRQ_FRAME_CYC
) (
	// Clock and reset
	input wire clock_i,
	input wire arst_n_i,
	// Frame events
	input wire sof_token_i,
	input wire enable_i,
	// Event
	output wire sof_evt_o
);
	localparam [31:0] LIMIT_W = FRAME_CYC + `UIRQ_SOF_SLACK_CYC;
	localparam [16:0] LIMIT = LIMIT_W[16:0];

	reg [16:0] cnt_r;
	reg [16:0] cnt_nxt;
	wire missed;

	// Missed frames are only synthesized after the first real token, so no frame is faked at power up
	reg seen_r;

	assign missed = seen_r && enable_i && (cnt_r == LIMIT - 17'h00001);
	assign sof_evt_o = sof_token_i | missed; // see [RULE_05]

	always @* begin
		if (sof_evt_o || !enable_i) begin
			cnt_nxt = 17'h00000;
		end else begin
			cnt_nxt = cnt_r + 17'h00001;
		end
	end

	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= 17'h00000;
			seen_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			if (!enable_i) begin
				seen_r <= 1'b0;
			end else if (sof_token_i) begin
				seen_r <= 1'b1;
			end
		end
	end
endmodule

// >>> rtl/uirq_flag_reg.v
// Sticky flag register: set wins over clear-on-read
`timescale 1ns/1ps
`include "uirq_defines.vh"
module uirq_flag_reg (
	// Clock and reset
	input wire clock_i,
	input wire arst_n_i,
	// Events and clear
	input wire [7:0] set_i,
	input wire [7:0] valid_i,
	input wire rd_clr_i,
	// Flags
	output reg [7:0] flags_o
);
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags_o <= `UIRQ_RST_FLAGS;
		end else if (rd_clr_i) begin
			// Event in the clearing cycle survives the read
			flags_o <= set_i & valid_i; // see [RULE_12]
		end else begin
			flags_o <= (flags_o | set_i) & valid_i; // see [RULE_10]
		end
	end
endmodule

// >>> sim/uirq_chk.sv
// Port checker for the interrupt flag block
`timescale 1ns/1ps
module uirq_chk (
	// Clock, reset and APB
	input wire clock_i, arst_n_i, psel_i, penable_i, pwrite_i,
	input wire [7:0] paddr_i,
	input wire pready_o, pslverr_o, irq_o,
	input wire [31:0] prdata_o,
	// Events
	input wire out_ep1_evt_i, out_ep2_evt_i, out_ep3_evt_i, sof_token_i,
	input wire bus_reset_evt_i, resume_evt_i, suspend_evt_i, suspend_mode_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	wire rd = psel_i && !penable_i && !pwrite_i;
	wire rd_out = rd && paddr_i == 8'h10;
	wire rd_bus = rd && paddr_i == 8'h18;
	wire ep_any = out_ep1_evt_i || out_ep2_evt_i || out_ep3_evt_i;
	wire bus_any = sof_token_i || bus_reset_evt_i || resume_evt_i || suspend_evt_i;
	a_ep1_flag: assert property (out_ep1_evt_i ##1 rd_out |=> prdata_o[1])
		else $error("ep1 flag missing");
	a_ep3_flag: assert property (out_ep3_evt_i ##1 rd_out |=> prdata_o[3])
		else $error("ep3 flag missing");
	a_out_clear: assert property (rd_out ##1 (penable_i && !ep_any) ##1 (!psel_i && !ep_any)
		##1 rd_out |=> prdata_o[3:1] == 3'h0) else $error("out flags kept");
	a_sof_flag: assert property (sof_token_i ##1 rd_bus |=> prdata_o[3])
		else $error("frame flag missing");
	a_rst_flag: assert property (bus_reset_evt_i ##1 rd_bus |=> prdata_o[2])
		else $error("reset flag missing");
	a_rsu_flag: assert property (resume_evt_i && suspend_mode_i ##1 rd_bus |=> prdata_o[1])
		else $error("resume flag missing");
	a_bus_clear: assert property (rd_bus ##1 (penable_i && !bus_any) ##1 (!psel_i && !bus_any)
		##1 rd_bus |=> prdata_o[3:0] == 4'h0) else $error("bus flags kept");
	a_unused_zero: assert property (rd_out |=> prdata_o[31:4] == 28'h0 && !prdata_o[0])
		else $error("unused bits set");
	a_irq_cause: assert property ($rose(irq_o) |-> $past(ep_any || bus_any || psel_i && pwrite_i))
		else $error("irq without cause");
	a_keep_other: assert property (bus_reset_evt_i ##2 rd_out ##2 !psel_i ##1 rd_bus
		|=> prdata_o[2]) else $error("other flags lost");
endmodule
bind uirq_top uirq_chk u_chk (.*);

// >>> sim/uirq_host.sv
// Bus-side event source standing in for the host and endpoint engines
`timescale 1ns/1ps
module uirq_host (
	input wire clock_i,
	output logic [6:0] evt_o,
	output logic suspend_mode_o
);
	initial begin
		evt_o = 7'h00;
		suspend_mode_o = 1'b0;
	end
	// Called at an edge; one-cycle pulses, suspend level held afterwards
	task send(input logic [6:0] which, input logic mode);
		suspend_mode_o <= mode;
		evt_o <= which;
		@(posedge clock_i);
		evt_o <= 7'h00;
	endtask
endmodule

// >>> sim/uirq_bench.sv
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module uirq_bench;
	logic clock_i, arst_n_i, psel_i, penable_i, pwrite_i, err, iqv;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, rdv;
	wire pready_o, pslverr_o, irq_o, suspend_mode_i;
	wire out_ep1_evt_i, out_ep2_evt_i, out_ep3_evt_i, sof_token_i;
	wire bus_reset_evt_i, resume_evt_i, suspend_evt_i;
	wire [31:0] prdata_o;
	wire [6:0] evt;
	int errors, cmp_count;
	typedef struct {logic [6:0] ev; logic md; logic [7:0] ad, dt; logic iq;} uirq_row_t;
	uirq_row_t rows[8] = '{'{7'h01, 0, 8'h10, 8'h02, 1}, '{7'h02, 0, 8'h10, 8'h04, 1},
		'{7'h04, 0, 8'h10, 8'h08, 1}, '{7'h08, 0, 8'h18, 8'h08, 0},
		'{7'h10, 0, 8'h18, 8'h04, 1}, '{7'h20, 0, 8'h18, 8'h00, 0},
		'{7'h20, 1, 8'h18, 8'h02, 1}, '{7'h40, 0, 8'h18, 8'h01, 0}};
	assign {suspend_evt_i, resume_evt_i, bus_reset_evt_i, sof_token_i} = evt[6:3];
	assign {out_ep3_evt_i, out_ep2_evt_i, out_ep1_evt_i} = evt[2:0];
	uirq_top u_dut (.*);
	uirq_host u_host (.clock_i(clock_i), .evt_o(evt), .suspend_mode_o(suspend_mode_i));
	initial begin
		clock_i = 0;
		forever #4 clock_i = ~clock_i;
	end
	task check(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Called at an edge; returns at the access edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1;
		penable_i <= 0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rdv = prdata_o;
		err = pslverr_o;
		iqv = irq_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock_i);
		apb(0, a, 0);
		check("read", rdv, exp);
	endtask
	task give_verdict;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clock_i);
		errors++;
		give_verdict;
	end
	initial begin
		{arst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		repeat (6) @(posedge clock_i);
		arst_n_i <= 1;
		@(posedge clock_i);
		check("irq", irq_o, 0);
		rd_chk(8'h10, 0);
		rd_chk(8'h10, 0);
		rd_chk(8'h18, 0);
		foreach (rows[i]) begin
			@(posedge clock_i);
			u_host.send(rows[i].ev, rows[i].md);
			apb(0, rows[i].ad, 0);
			check("flags", rdv, rows[i].dt);
			check("irq", iqv, rows[i].iq);
			@(posedge clock_i);
			check("irq after read", irq_o, 0);
		end
		@(posedge clock_i);
		u_host.send(7'h11, 0);
		rd_chk(8'h10, 32'h02);
		rd_chk(8'h18, 32'h04);
		rd_chk(8'h18, 0);
		@(posedge clock_i);
		apb(1, 8'h10, 32'hFF);
		rd_chk(8'h10, 0);
		rd_chk(8'h30, 0);
		check("slverr", err, 1);
		@(posedge clock_i);
		apb(1, 8'h2C, 32'h08);
		@(posedge clock_i);
		u_host.send(7'h08, 0);
		@(posedge clock_i);
		check("irq frame", irq_o, 1);
		rd_chk(8'h18, 32'h08);
		@(posedge clock_i);
		apb(1, 8'h40, 0);
		@(posedge clock_i);
		u_host.send(7'h40, 0);
		rd_chk(8'h18, 0);
		give_verdict;
	end
endmodule
